// >>> test/mtcc_far.sv
`timescale 1ns/100ps
// ****************************************
// table walk memory and ea primitive model
// ****************************************
module mtcc_far (
    // clock and reset
    input wire clk,
    input wire reset,
    // requests from the unit
    input wire walk_req,
    input wire ea_req,
    // bench controls
    input wire [22:0] desc_in,
    input wire [3:0] lat,
    input wire fault_in,
    // answers
    output reg walk_ack,
    output reg [22:0] walk_desc,
    output reg ea_done,
    output reg ea_fault
);
    reg [3:0] cnt_r;
    always @(posedge clk) begin
        walk_ack <= 1'b0;
        ea_done <= 1'b0;
        ea_fault <= 1'b0;
        // released bus shows a moving pattern, not a held value
        walk_desc <= ~walk_desc;
        if (reset) begin
            cnt_r <= 4'h0;
            walk_desc <= 23'h0;
        end else if ((walk_req && !walk_ack) || (ea_req && !ea_done)) begin
            if (cnt_r == lat) begin
                cnt_r <= 4'h0;
                if (walk_req) begin
                    walk_ack <= 1'b1;
                    walk_desc <= desc_in;
                end else begin
                    ea_done <= 1'b1;
                    ea_fault <= fault_in;
                end
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule // mtcc_far

// >>> test/mtcc_top_bench.sv
`timescale 1ns/100ps
`include "mtcc_defs.vh"
module mtcc_top_bench;
    reg clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    reg [5:0] reg_addr = 6'h00;
    reg [31:0] reg_wdata = 32'h0, acc_addr = 32'h0, rv, base_seen, addr_seen;
    reg acc_valid = 1'b0, acc_write = 1'b0, fault_in = 1'b0, viol_seen;
    reg [3:0] acc_fc = 4'h0, lat = 4'h2, fc;
    reg [22:0] desc_in = 23'h0;
    reg [2:0] idx_seen, res;
    wire [31:0] reg_rdata, acc_paddr, walk_base, walk_addr;
    wire [22:0] walk_desc;
    wire [2:0] walk_index;
    wire acc_done, acc_miss, acc_berr, walk_req, walk_ack, ea_req;
    wire ea_done, ea_fault, op_done, op_viol, irq;
    integer err_count = 0, total_checks = 0, i;
    // per-case tables, entry 0 in the low bits
    localparam [15:0] FCS = 16'h95d1;
    localparam [11:0] ATS = 12'b011_011_001_101;
    localparam [47:0] ACS = 48'h00_82_82_80_00_00;
    localparam [47:0] CMS = 48'h0b_3b_1b_0b_03_0b;
    localparam [5:0] VIOLS = 6'b001001;
    always #2.5 clk = ~clk;
    mtcc_top DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .acc_fc(acc_fc), .acc_write(acc_write), .acc_done(acc_done),
        .acc_miss(acc_miss), .acc_berr(acc_berr), .acc_paddr(acc_paddr),
        .walk_req(walk_req), .walk_base(walk_base), .walk_index(walk_index),
        .walk_addr(walk_addr), .walk_ack(walk_ack), .walk_desc(walk_desc),
        .ea_req(ea_req), .ea_done(ea_done), .ea_fault(ea_fault),
        .op_done(op_done), .op_viol(op_viol), .irq(irq));
    mtcc_far far (.clk(clk), .reset(reset), .walk_req(walk_req),
        .ea_req(ea_req), .desc_in(desc_in), .lat(lat), .fault_in(fault_in),
        .walk_ack(walk_ack), .walk_desc(walk_desc), .ea_done(ea_done),
        .ea_fault(ea_fault));
    // ****************************************
    // shared tasks
    // ****************************************
    task conclude;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] s, input [31:0] e);
        begin
            total_checks = total_checks + 1;
            if (s !== e) begin
                err_count = err_count + 1;
                $display("unexpected at %0t: got %h want %h", $time, s, e);
            end
        end
    endtask
    task wr(input [5:0] a, input [31:0] d);
        begin
            @(posedge clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [5:0] a);
        begin
            @(posedge clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 rv = reg_rdata;
        end
    endtask
    // bounded wait for completion, walk values caught on the way
    task op(input [31:0] c);
        integer n;
        begin
            wr(`MTCC_A_CMD, c);
            n = 0;
            // one-cycle ops answer in the cycle right after the write
            #1;
            while (op_done !== 1'b1 && n < 60) begin
                if (walk_req === 1'b1) begin
                    base_seen = walk_base;
                    addr_seen = walk_addr;
                    idx_seen = walk_index;
                end
                n = n + 1;
                @(posedge clk);
                #1;
            end
            if (n >= 60) begin
                err_count = err_count + 1;
                $display("unexpected at %0t: operation hung", $time);
                conclude;
            end
            viol_seen = op_viol;
        end
    endtask
    task pre(input [19:0] pg, input [3:0] f, input [2:0] at);
        begin
            desc_in <= {at, pg + 20'h00100};
            wr(`MTCC_A_PADDR, {pg, 12'h000});
            op({20'h0, f, 5'h00, `MTCC_OP_PRELOAD});
        end
    endtask
    task acc(input [19:0] pg, input w);
        begin
            @(posedge clk);
            acc_valid <= 1'b1;
            acc_addr <= {pg, 12'h034};
            acc_write <= w;
            acc_fc <= 4'h1;
            @(posedge clk);
            acc_valid <= 1'b0;
            #1 res = {acc_done, acc_miss, acc_berr};
        end
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd(`MTCC_A_AC);
        chk(rv, `MTCC_RST_WORD);
        rd(6'h3c);
        chk(rv, 32'h0);
        wr(`MTCC_A_CRP, 32'h1000);
        wr(`MTCC_A_SRP, 32'h2000);
        wr(`MTCC_A_DRP, 32'h3000);
        wr(`MTCC_A_CFG, 32'h1);
        for (i = 0; i < 4; i = i + 1) begin
            fc = FCS[4*i +: 4];
            pre(i + 1, fc, ATS[3*i +: 3]);
            chk(base_seen, fc[3] ? 32'h3000 : fc[2] ? 32'h2000 : 32'h1000);
            chk({29'h0, idx_seen}, {29'h0, fc[2:0]});
            chk(addr_seen, (i + 1) * 32'h1000);
        end
        // cache now full of locked entries: no victim left
        wr(`MTCC_A_CFG, 32'h0);
        pre(20'h5, 4'h5, 3'b000);
        chk(base_seen, 32'h1000);
        rd(`MTCC_A_STAT);
        chk(rv & 32'h10, 32'h10);
        acc(20'h1, 1'b1);
        chk({29'h0, res}, 32'h1);
        acc(20'h1, 1'b0);
        chk({29'h0, res}, 32'h4);
        chk(acc_paddr, 32'h0010_1034);
        acc(20'h5, 1'b0);
        chk({29'h0, res}, 32'h2);
        op({29'h0, `MTCC_OP_FLUSHS});
        acc(20'h3, 1'b0);
        chk({29'h0, res}, 32'h2);
        acc(20'h4, 1'b0);
        chk({29'h0, res}, 32'h2);
        acc(20'h2, 1'b0);
        chk({29'h0, res}, 32'h4);
        // range marks page 2 shared although its descriptor does not
        wr(`MTCC_A_SGLO, 32'h0000_2000);
        wr(`MTCC_A_SGHI, 32'h0000_2000);
        op({29'h0, `MTCC_OP_FLUSHS});
        acc(20'h2, 1'b0);
        chk({29'h0, res}, 32'h2);
        acc(20'h1, 1'b0);
        chk({29'h0, res}, 32'h4);
        wr(`MTCC_A_MASK, 32'h2);
        for (i = 0; i < 6; i = i + 1) begin
            fault_in <= (i == 5);
            wr(`MTCC_A_AC, {24'h0, ACS[8*i +: 8]});
            op({24'h0, CMS[8*i +: 8]});
            chk({31'h0, viol_seen}, {31'h0, VIOLS[i]});
            @(posedge clk);
            #1;
            chk({31'h0, irq}, {31'h0, VIOLS[i]});
            rd(`MTCC_A_STAT);
            chk(rv & 32'h6, {29'h0, i == 5, VIOLS[i], 1'b0});
            chk({31'h0, irq}, 32'h0);
        end
        // disabled breakpoint is saved as zero and not reloaded
        wr(`MTCC_A_CRP, 32'ha000);
        wr(`MTCC_A_BP0, 32'h8000_00ab);
        wr(`MTCC_A_BP1, 32'h0000_00cd);
        op({29'h0, `MTCC_OP_SAVE});
        wr(`MTCC_A_CRP, 32'h5000);
        wr(`MTCC_A_BP0, 32'h0);
        wr(`MTCC_A_BP1, 32'h0000_00ef);
        op({29'h0, `MTCC_OP_RESTORE});
        rd(`MTCC_A_CRP);
        chk(rv, 32'ha000);
        rd(`MTCC_A_BP0);
        chk(rv, 32'h8000_00ab);
        rd(`MTCC_A_BP1);
        chk(rv, 32'h0000_00ef);
        rd(`MTCC_A_SRP);
        chk(rv, 32'h2000);
        conclude;
    end
endmodule // mtcc_top_bench

// >>> test/mtcc_top_sva.sv
`timescale 1ns/100ps
module mtcc_top_sva (
    // clock and reset
    input wire clk,
    input wire reset,
    // register and access ports
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire acc_valid,
    input wire acc_write,
    input wire acc_done,
    input wire acc_miss,
    input wire acc_berr,
    // walk and primitive ports
    input wire walk_req,
    input wire [31:0] walk_base,
    input wire [2:0] walk_index,
    input wire walk_ack,
    input wire ea_req,
    input wire ea_done,
    input wire ea_fault,
    input wire op_done,
    input wire op_viol
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_walk_end;
        !walk_req && op_done;
    endsequence
    sequence s_ea_end;
        !ea_req && op_done;
    endsequence
    a_walk_hold: assert property (walk_req && !walk_ack |=>
        walk_req && $stable(walk_base) && $stable(walk_index))
        else $error("walk request dropped or base moved");
    a_walk_close: assert property (walk_req && walk_ack |=> s_walk_end)
        else $error("preload did not end after walk answer");
    a_ea_hold: assert property (ea_req && !ea_done |=> ea_req)
        else $error("ea request dropped early");
    a_ea_close: assert property (ea_req && ea_done |=> s_ea_end)
        else $error("validate did not end after ea answer");
    a_viol_late: assert property (op_viol |->
        op_done && $past(ea_done && !ea_fault))
        else $error("violation without completed ea primitive");
    a_berr_cause: assert property (acc_berr |->
        $past(acc_valid && acc_write) && !acc_done && !acc_miss)
        else $error("bus error without a write access");
    a_resp_cause: assert property ((acc_done || acc_miss) |->
        $past(acc_valid) && !(acc_done && acc_miss))
        else $error("access answer without request");
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule // mtcc_top_sva
bind mtcc_top mtcc_top_sva u_sva (.clk(clk), .reset(reset),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_done(acc_done), .acc_miss(acc_miss),
    .acc_berr(acc_berr), .walk_req(walk_req), .walk_base(walk_base),
    .walk_index(walk_index), .walk_ack(walk_ack), .ea_req(ea_req),
    .ea_done(ea_done), .ea_fault(ea_fault), .op_done(op_done),
    .op_viol(op_viol));

// >>> verilog/mtcc_defs.vh
`ifndef MTCC_DEFS_VH
`define MTCC_DEFS_VH
// ****************************************************************
// register offsets (byte addresses, one word each)
// ****************************************************************
`define MTCC_A_AC 6'h00
`define MTCC_A_CFG 6'h04
`define MTCC_A_CRP 6'h08
`define MTCC_A_SRP 6'h0c
`define MTCC_A_DRP 6'h10
`define MTCC_A_BP0 6'h14
`define MTCC_A_BP1 6'h18
`define MTCC_A_CMD 6'h1c
`define MTCC_A_PADDR 6'h20
`define MTCC_A_STAT 6'h24
`define MTCC_A_MASK 6'h28
`define MTCC_A_SGLO 6'h2c
`define MTCC_A_SGHI 6'h30
`define MTCC_A_COPST 6'h34
// ****************************************************************
// field positions
// ****************************************************************
`define MTCC_AC_MODEN 7
`define MTCC_AC_ALC_HI 1
`define MTCC_CFG_SUPEN 0
`define MTCC_BP_EN 31
`define MTCC_D_LOCK 20
`define MTCC_D_SG 21
`define MTCC_D_WP 22
`define MTCC_ST_DONE 0
`define MTCC_ST_VIOL 1
`define MTCC_ST_PF 2
`define MTCC_ST_BERR 3
`define MTCC_ST_PLFAIL 4
// ****************************************************************
// command codes and reset values
// ****************************************************************
`define MTCC_OP_SAVE 3'h1
`define MTCC_OP_RESTORE 3'h2
`define MTCC_OP_VALID 3'h3
`define MTCC_OP_PRELOAD 3'h4
`define MTCC_OP_FLUSHS 3'h5
`define MTCC_RST_WORD 32'h0000_0000
`define MTCC_RST_STAT 5'h00
`endif

// >>> verilog/mtcc_top.v
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "mtcc_defs.vh"
// Overview of operation
// - save captures, restore reloads state, interface state, enabled breakpoints, roots
// - write to write-protected page raises bus error for that access
// - access control bit 7 set enables module operations
// - disabled modules: user validate ends in access violation unless the effective address primitive faults
// - violation reported only after effective address primitive completes
// - enabled with zero level count: every validate is legal
// - locked entries are never chosen as cache victims
// - shared-global entries are never evicted by root table replacement
// - flush-shared removes shared entries, locked ones included
// - preload walks tables and inserts descriptor into the cache if a victim is found, else sets preload-fail status
// - shared-global may cover a range; lock is per page only
// - function code bit 3 high selects the dma root pointer
// - dma tree top level indexed by access function code
module mtcc_top (
    // clock and reset
    input wire clk,
    input wire reset,
    // register port
    input wire [5:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [31:0] reg_rdata,
    // translated access port
    input wire acc_valid,
    input wire [31:0] acc_addr,
    input wire [3:0] acc_fc,
    input wire acc_write,
    output wire acc_done,
    output wire acc_miss,
    output wire acc_berr,
    output wire [31:0] acc_paddr,
    // table walk port
    output wire walk_req,
    output wire [31:0] walk_base,
    output wire [2:0] walk_index,
    output wire [31:0] walk_addr,
    input wire walk_ack,
    input wire [22:0] walk_desc,
    // effective address primitive
    output wire ea_req,
    input wire ea_done,
    input wire ea_fault,
    // operation results
    output wire op_done,
    output wire op_viol,
    output wire irq
);
    // ****************************************************************
    // states
    // ****************************************************************
    localparam ST_IDLE = 3'b001;
    localparam ST_EA = 3'b010;
    localparam ST_WALK = 3'b100;

    reg [2:0] state_r;
    reg [31:0] ac_r, cfg_r, crp_r, srp_r, drp_r, bp0_r, bp1_r;
    reg [31:0] paddr_r, sglo_r, sghi_r;
    reg [4:0] stat_r, mask_r;
    reg [2:0] op_r;
    reg user_r;
    reg [3:0] lvl_r;
    reg [3:0] opfc_r;
    reg [31:0] rdata_r;
    reg done_r, viol_r;
    reg adone_r, amiss_r, aberr_r;
    reg [31:0] apaddr_r;
    reg [31:0] save_mem [0:7];
    reg [19:0] ct_tag [0:3];
    reg [19:0] ct_phys [0:3];
    reg [3:0] ct_val, ct_lock, ct_sg, ct_wp;
    reg [1:0] rr_r;
    integer i;
    integer j;

    // ****************************************************************
    // root selection
    // ****************************************************************
    function [31:0] root_sel;
        input [3:0] fc;
        begin
            if (fc[3]) begin
                root_sel = drp_r;
            end else if (cfg_r[`MTCC_CFG_SUPEN] && fc[2]) begin
                root_sel = srp_r;
            end else begin
                root_sel = crp_r;
            end
        end
    endfunction

    function in_sg_range;
        input [19:0] page;
        begin
            // range only for shared-global, lock stays per page
            in_sg_range = (page >= sglo_r[31:12]) &&
                (page <= sghi_r[31:12]);
        end
    endfunction

    // ****************************************************************
    // cache lookup and victim choice
    // ****************************************************************
    reg hit;
    reg [1:0] hit_idx;
    reg found;
    reg [1:0] vic_idx;
    reg [1:0] k;
    wire [19:0] acc_page = acc_addr[31:12];
    wire [19:0] pl_page = paddr_r[31:12];
    wire [3:0] eff_sg;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_sg
            assign eff_sg[g] = ct_sg[g] | in_sg_range(ct_tag[g]);
        end
    endgenerate

    always @* begin
        hit = 1'b0;
        hit_idx = 2'h0;
        for (i = 0; i < 4; i = i + 1) begin
            if (!hit && ct_val[i] && ct_tag[i] == acc_page) begin
                hit = 1'b1;
                hit_idx = i[1:0];
            end
        end
    end

    always @* begin
        found = 1'b0;
        vic_idx = 2'h0;
        k = 2'h0;
        for (j = 0; j < 4; j = j + 1) begin
            if (!found && !ct_val[j]) begin
                found = 1'b1;
                vic_idx = j[1:0];
            end
        end
        // round robin, skipping entries that must stay resident
        for (j = 0; j < 4; j = j + 1) begin
            k = rr_r + j[1:0];
            if (!found && !ct_lock[k] && !eff_sg[k]) begin
                found = 1'b1;
                vic_idx = k;
            end
        end
    end

    // ****************************************************************
    // operation sequencer and registers
    // ****************************************************************
    wire wr_cmd = reg_wr && reg_addr == `MTCC_A_CMD;
    wire mod_en = ac_r[`MTCC_AC_MODEN];
    wire [1:0] access_level_count_field = ac_r[`MTCC_AC_ALC_HI:0];
    wire wp_hit = acc_valid && acc_write && hit && ct_wp[hit_idx];
    reg [4:0] st_set;
    reg [4:0] stat_nxt;

    always @* begin
        st_set = 5'h00;
        if (wp_hit) begin
            st_set[`MTCC_ST_BERR] = 1'b1;
        end
        if (done_r) begin
            st_set[`MTCC_ST_DONE] = 1'b1;
        end
        if (viol_r) begin
            st_set[`MTCC_ST_VIOL] = 1'b1;
        end
        if (state_r == ST_EA && ea_done && ea_fault) begin
            st_set[`MTCC_ST_PF] = 1'b1;
        end
        if (state_r == ST_WALK && walk_ack && !found) begin
            st_set[`MTCC_ST_PLFAIL] = 1'b1;
        end
        // a new event in the clearing read survives it
        stat_nxt = stat_r | st_set;
        if (reg_rd && reg_addr == `MTCC_A_STAT) begin
            stat_nxt = st_set;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            ac_r <= `MTCC_RST_WORD;
            cfg_r <= `MTCC_RST_WORD;
            crp_r <= `MTCC_RST_WORD;
            srp_r <= `MTCC_RST_WORD;
            drp_r <= `MTCC_RST_WORD;
            bp0_r <= `MTCC_RST_WORD;
            bp1_r <= `MTCC_RST_WORD;
            paddr_r <= `MTCC_RST_WORD;
            sglo_r <= `MTCC_RST_WORD;
            sghi_r <= `MTCC_RST_WORD;
            stat_r <= `MTCC_RST_STAT;
            mask_r <= `MTCC_RST_STAT;
            op_r <= 3'h0;
            user_r <= 1'b0;
            lvl_r <= 4'h0;
            opfc_r <= 4'h0;
            done_r <= 1'b0;
            viol_r <= 1'b0;
            ct_val <= 4'h0;
            ct_lock <= 4'h0;
            ct_sg <= 4'h0;
            ct_wp <= 4'h0;
            rr_r <= 2'h0;
        end else begin
            stat_r <= stat_nxt;
            done_r <= 1'b0;
            viol_r <= 1'b0;
            if (reg_wr) begin
                case (reg_addr)
                    `MTCC_A_AC: ac_r <= reg_wdata;
                    `MTCC_A_CFG: cfg_r <= reg_wdata;
                    `MTCC_A_CRP: crp_r <= reg_wdata;
                    `MTCC_A_SRP: srp_r <= reg_wdata;
                    `MTCC_A_DRP: drp_r <= reg_wdata;
                    `MTCC_A_BP0: bp0_r <= reg_wdata;
                    `MTCC_A_BP1: bp1_r <= reg_wdata;
                    `MTCC_A_PADDR: paddr_r <= reg_wdata;
                    `MTCC_A_MASK: mask_r <= reg_wdata[4:0];
                    `MTCC_A_SGLO: sglo_r <= reg_wdata;
                    `MTCC_A_SGHI: sghi_r <= reg_wdata;
                    default: ;
                endcase
            end
            case (state_r)
                ST_IDLE: begin
                    // commands while busy are dropped, see COPST
                    if (wr_cmd) begin
                        op_r <= reg_wdata[2:0];
                        user_r <= reg_wdata[3];
                        lvl_r <= reg_wdata[7:4];
                        opfc_r <= reg_wdata[11:8];
                        case (reg_wdata[2:0])
                            `MTCC_OP_SAVE: begin
                                save_mem[0] <= ac_r;
                                save_mem[1] <= cfg_r;
                                save_mem[2] <= crp_r;
                                save_mem[3] <= srp_r;
                                save_mem[4] <= drp_r;
                                save_mem[5] <= bp0_r[`MTCC_BP_EN] ?
                                    bp0_r : `MTCC_RST_WORD;
                                save_mem[6] <= bp1_r[`MTCC_BP_EN] ?
                                    bp1_r : `MTCC_RST_WORD;
                                save_mem[7] <= {29'h0, op_r};
                                done_r <= 1'b1;
                            end
                            `MTCC_OP_RESTORE: begin
                                ac_r <= save_mem[0];
                                cfg_r <= save_mem[1];
                                crp_r <= save_mem[2];
                                srp_r <= save_mem[3];
                                drp_r <= save_mem[4];
                                if (save_mem[5][`MTCC_BP_EN]) begin
                                    bp0_r <= save_mem[5];
                                end
                                if (save_mem[6][`MTCC_BP_EN]) begin
                                    bp1_r <= save_mem[6];
                                end
                                op_r <= save_mem[7][2:0];
                                done_r <= 1'b1;
                            end
                            `MTCC_OP_VALID: state_r <= ST_EA;
                            `MTCC_OP_PRELOAD: state_r <= ST_WALK;
                            `MTCC_OP_FLUSHS: begin
                                ct_val <= ct_val & ~eff_sg;
                                done_r <= 1'b1;
                            end
                            default: ;
                        endcase
                    end
                end
                ST_EA: begin
                    // the verdict waits for the address primitive
                    if (ea_done) begin
                        state_r <= ST_IDLE;
                        done_r <= 1'b1;
                        if (ea_fault) begin
                            viol_r <= 1'b0;
                        end else if (!mod_en) begin
                            viol_r <= user_r;
                        end else if (access_level_count_field == 2'h0) begin
                            viol_r <= 1'b0;
                        end else begin
                            viol_r <= user_r && (lvl_r < {2'h0, access_level_count_field});
                        end
                    end
                end
                ST_WALK: begin
                    if (walk_ack) begin
                        state_r <= ST_IDLE;
                        done_r <= 1'b1;
                        if (found) begin
                            ct_val[vic_idx] <= 1'b1;
                            ct_tag[vic_idx] <= pl_page;
                            ct_phys[vic_idx] <= walk_desc[19:0];
                            ct_lock[vic_idx] <= walk_desc[`MTCC_D_LOCK];
                            ct_sg[vic_idx] <= walk_desc[`MTCC_D_SG];
                            ct_wp[vic_idx] <= walk_desc[`MTCC_D_WP];
                            rr_r <= vic_idx + 2'h1;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // access port
    // ****************************************************************
    always @(posedge clk) begin
        if (reset) begin
            adone_r <= 1'b0;
            amiss_r <= 1'b0;
            aberr_r <= 1'b0;
            apaddr_r <= `MTCC_RST_WORD;
        end else begin
            adone_r <= acc_valid && hit && !wp_hit;
            amiss_r <= acc_valid && !hit;
            aberr_r <= wp_hit;
            if (acc_valid && hit) begin
                apaddr_r <= {ct_phys[hit_idx], acc_addr[11:0]};
            end
        end
    end

    // ****************************************************************
    // register read
    // ****************************************************************
    always @(posedge clk) begin
        if (reset) begin
            rdata_r <= `MTCC_RST_WORD;
        end else if (reg_rd) begin
            case (reg_addr)
                `MTCC_A_AC: rdata_r <= ac_r;
                `MTCC_A_CFG: rdata_r <= cfg_r;
                `MTCC_A_CRP: rdata_r <= crp_r;
                `MTCC_A_SRP: rdata_r <= srp_r;
                `MTCC_A_DRP: rdata_r <= drp_r;
                `MTCC_A_BP0: rdata_r <= bp0_r;
                `MTCC_A_BP1: rdata_r <= bp1_r;
                `MTCC_A_PADDR: rdata_r <= paddr_r;
                `MTCC_A_STAT: rdata_r <= {27'h0, stat_r};
                `MTCC_A_MASK: rdata_r <= {27'h0, mask_r};
                `MTCC_A_SGLO: rdata_r <= sglo_r;
                `MTCC_A_SGHI: rdata_r <= sghi_r;
                `MTCC_A_COPST: rdata_r <= {ct_sg, ct_lock, ct_val,
                    14'h0, op_r, state_r};
                default: rdata_r <= `MTCC_RST_WORD;
            endcase
        end else begin
            rdata_r <= `MTCC_RST_WORD;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reg_rdata = rdata_r;
    assign acc_done = adone_r;
    assign acc_miss = amiss_r;
    assign acc_berr = aberr_r;
    assign acc_paddr = apaddr_r;
    assign walk_req = state_r == ST_WALK;
    assign walk_base = root_sel(opfc_r);
    assign walk_index = opfc_r[2:0];
    assign walk_addr = paddr_r;
    assign ea_req = state_r == ST_EA;
    assign op_done = done_r;
    assign op_viol = viol_r;
    assign irq = |(stat_r & mask_r);
endmodule // mtcc_top
